/* logic/uhts_token_sched.sv */
// Host token and start-of-frame scheduler with APB register file.
// Assumes a packet engine on pclk that takes tok_start/tok and answers
// with tok_end (plus tok_retry); attach and speed arrive from pins.
//
// What this block does
// - Attach flag reads device presence
// - Frame match sets event at SOF start
// - Frame event interrupts only when enabled
// - Retry countdown loads at start, ticks bitwise
// - Retry count freezes in end-of-frame window
// - Retry time survives soft reset, writes dropped
// - Function mode hides low retry bits
// - Address field goes into every token
// - Data tokens deferred inside guard window
// - Guard counted in bit times
// - SOF command starts 1 ms timer
// - Eleven-bit frame counts up, soft reset clears
// - Toggle selects DATA0/1, checks received toggle
// - Three-bit token type decoding
// - Completion clears type, sets done event
// - SOF ignores toggle and endpoint
// - No tokens while detached
// - Endpoint field addresses target endpoint
// - Preamble packets unsupported
// - Busy flag stops on written zero, polled
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module uhts_token_sched #(
  parameter int unsigned FRAME_BITS = uhts_pkg::FRAME_BITS_D
) (
  // APB slave
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Link pins and controller mode
  input  wire logic                 dev_attach_pin,
  input  wire logic                 dev_full_speed_pin,
  input  wire logic                 host_mode,
  // Packet engine
  output logic                      tok_start,
  output uhts_pkg::uhts_token_type  tok,
  input  wire logic                 tok_end,
  input  wire logic                 tok_retry,
  input  wire logic                 rx_tgl_valid,
  input  wire logic                 rx_tgl,
  // Status outputs
  output logic                      toggle_err,
  output logic                      irq
);

  typedef enum logic [1:0] {S_IDLE, S_TOKEN, S_RETRY, S_SOF} uhts_state_type;

  // Counter must fit the 14-bit timer and the guard compare
  if (FRAME_BITS < 2 || FRAME_BITS > 16383) begin : g_chk
    $error("FRAME_BITS out of range");
  end

  localparam logic [13:0] FRAME_LAST = 14'(FRAME_BITS - 1);

  uhts_state_type state_r;
  uhts_state_type ret_r;
  logic        att_meta_r, att_r, spd_meta_r, spd_r;
  logic [6:0]  acc_r;
  logic [7:0]  acc_sum;
  logic        tick_r;
  logic        soft_rst_r, step_r, fire_r, cire_r, retry_en_r;
  logic        ev_frame_r, ev_done_r;
  logic [7:0]  match_r;
  logic [17:0] retry_r, rcnt_r;
  logic [6:0]  addr_r;
  logic [13:0] guard_r, sof_cnt_r;
  logic [10:0] frame_r;
  logic        tgl_r;
  logic [2:0]  type_r;
  logic [3:0]  ep_r;
  logic        busy_r, stop_req_r, sof_due_r, sof_cmd_r;
  logic        setup, acc_go, wr, hit;
  logic [31:0] rd_mux;
  logic        link_ok, is_data, is_xfer, eof_win, freeze;
  logic        sof_go, tok_go, done_go, sof_cmd_go;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      att_meta_r <= 1'b0;
      att_r      <= 1'b0;
      spd_meta_r <= 1'b0;
      spd_r      <= 1'b0;
    end else begin
      att_meta_r <= dev_attach_pin;
      att_r      <= att_meta_r;
      spd_meta_r <= dev_full_speed_pin;
      spd_r      <= spd_meta_r;
    end
  end

  // Full-speed bit tick: 12 of every 40 clocks, no fractional drift
  assign acc_sum = {1'b0, acc_r} + 8'(uhts_pkg::TICK_STEP);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r  <= 7'h00;
      tick_r <= 1'b0;
    end else if (acc_sum >= 8'(uhts_pkg::TICK_MOD)) begin
      acc_r  <= 7'(acc_sum - 8'(uhts_pkg::TICK_MOD));
      tick_r <= 1'b1;
    end else begin
      acc_r  <= acc_sum[6:0];
      tick_r <= 1'b0;
    end
  end

  // Scheduling conditions
  assign link_ok = att_r & host_mode & ~soft_rst_r;
  assign is_data = (type_r == uhts_pkg::PID_SETUP) |
                   (type_r == uhts_pkg::PID_IN) |
                   (type_r == uhts_pkg::PID_OUT);
  assign is_xfer = is_data | (type_r == uhts_pkg::PID_ISOIN) |
                   (type_r == uhts_pkg::PID_ISOUT);
  assign eof_win = busy_r & (sof_cnt_r < guard_r);
  assign freeze  = eof_win | sof_due_r | (state_r == S_SOF);
  assign sof_go  = link_ok & sof_due_r &
                   ((state_r == S_IDLE) | (state_r == S_RETRY));
  assign tok_go  = (state_r == S_IDLE) & ~sof_go & link_ok & is_xfer &
                   ~(is_data & eof_win);
  assign sof_cmd_go = (state_r == S_IDLE) & link_ok & ~busy_r &
                      (type_r == uhts_pkg::PID_SOF);
  assign done_go = ((state_r == S_TOKEN) & tok_end &
                    ~(tok_retry & retry_en_r)) |
                   ((state_r == S_SOF) & tok_end & sof_cmd_r);

  // APB decode; one-cycle access phase, unmapped answers pslverr
  assign setup  = psel & ~penable;
  assign acc_go = psel & penable & pready;
  assign wr     = acc_go & pwrite;
  assign hit    = (paddr[1:0] == 2'b00) & (paddr <= uhts_pkg::OFS_TOKEN);

  // Read data view of the register file
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      uhts_pkg::OFS_CORE:  rd_mux[uhts_pkg::CORE_RST] = soft_rst_r;
      uhts_pkg::OFS_HCTL:  rd_mux[3:0] = {retry_en_r, cire_r, fire_r,
                                          step_r};
      uhts_pkg::OFS_EVENT: rd_mux[1:0] = {ev_done_r, ev_frame_r};
      uhts_pkg::OFS_STATE: begin
        rd_mux[uhts_pkg::ST_ATTACH] = att_r;
        rd_mux[uhts_pkg::ST_SPEED]  = spd_r;
        rd_mux[uhts_pkg::ST_BUSY]   = busy_r;
      end
      uhts_pkg::OFS_MATCH: rd_mux[7:0]  = match_r;
      uhts_pkg::OFS_RETRY: rd_mux[17:0] = host_mode ? retry_r :
                                          {retry_r[17:16], 16'h0000};
      uhts_pkg::OFS_ADDR:  rd_mux[6:0]  = addr_r;
      uhts_pkg::OFS_GUARD: rd_mux[13:0] = guard_r;
      uhts_pkg::OFS_FRAME: rd_mux[10:0] = frame_r;
      uhts_pkg::OFS_TOKEN: rd_mux[7:0]  = {tgl_r, type_r, ep_r};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // Answer registered in setup so all bus outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= setup ? rd_mux : 32'h0000_0000;
    end
  end

  // Control and plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_r <= uhts_pkg::CORE_RST_INIT;
      step_r     <= 1'b0;
      fire_r     <= 1'b0;
      cire_r     <= 1'b0;
      retry_en_r <= 1'b0;
      match_r    <= uhts_pkg::MATCH_INIT;
      addr_r     <= uhts_pkg::ADDR_INIT;
      guard_r    <= uhts_pkg::GUARD_INIT;
    end else if (wr) begin
      case (paddr)
        uhts_pkg::OFS_CORE:  soft_rst_r <= pwdata[uhts_pkg::CORE_RST];
        uhts_pkg::OFS_HCTL: begin
          step_r     <= pwdata[uhts_pkg::HCTL_STEP];
          fire_r     <= pwdata[uhts_pkg::HCTL_FIRE];
          cire_r     <= pwdata[uhts_pkg::HCTL_CIRE];
          retry_en_r <= pwdata[uhts_pkg::HCTL_RETRY];
        end
        uhts_pkg::OFS_MATCH: match_r <= pwdata[7:0];
        uhts_pkg::OFS_ADDR:  addr_r  <= pwdata[6:0];
        uhts_pkg::OFS_GUARD: guard_r <= pwdata[13:0];
        default: ;
      endcase
    end
  end

  // Retry time: kept over soft reset, low 16 bits host-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_r <= uhts_pkg::RETRY_INIT;
    end else if (wr && paddr == uhts_pkg::OFS_RETRY && !soft_rst_r) begin
      retry_r[17:16] <= pwdata[17:16];
      if (host_mode) begin
        retry_r[15:0] <= pwdata[15:0];
      end
    end
  end

  // Token command; hardware clear on completion beats a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_r  <= 1'b0;
      type_r <= uhts_pkg::PID_NONE;
      ep_r   <= 4'h0;
    end else if (soft_rst_r) begin
      tgl_r  <= 1'b0;
      type_r <= uhts_pkg::PID_NONE;
      ep_r   <= 4'h0;
    end else if (done_go) begin
      type_r <= uhts_pkg::PID_NONE;
    end else if (wr && paddr == uhts_pkg::OFS_TOKEN) begin
      tgl_r  <= pwdata[uhts_pkg::TK_TGL];
      type_r <= pwdata[uhts_pkg::TK_TYPE_LO +: 3];
      ep_r   <= pwdata[uhts_pkg::TK_EP_LO +: 4];
    end
  end

  // Event flags: write 0 clears, write 1 ignored, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_frame_r <= 1'b0;
      ev_done_r  <= 1'b0;
    end else if (soft_rst_r) begin
      ev_frame_r <= 1'b0;
      ev_done_r  <= 1'b0;
    end else begin
      if (sof_go && !step_r && match_r == frame_r[7:0]) begin
        ev_frame_r <= 1'b1;
      end else if (wr && paddr == uhts_pkg::OFS_EVENT &&
                   !pwdata[uhts_pkg::EV_FRAME]) begin
        ev_frame_r <= 1'b0;
      end
      if (done_go) begin
        ev_done_r <= 1'b1;
      end else if (wr && paddr == uhts_pkg::OFS_EVENT &&
                   !pwdata[uhts_pkg::EV_DONE]) begin
        ev_done_r <= 1'b0;
      end
    end
  end

  // Frame number: counts each finished SOF, soft reset clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_r <= uhts_pkg::FRAME_INIT;
    end else if (soft_rst_r) begin
      frame_r <= uhts_pkg::FRAME_INIT;
    end else if (state_r == S_SOF && tok_end) begin
      frame_r <= frame_r + 11'h001;
    end else if (wr && paddr == uhts_pkg::OFS_FRAME) begin
      frame_r <= pwdata[10:0];
    end
  end

  // SOF timer and busy flag; a stop waits for any SOF in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r     <= 1'b0;
      stop_req_r <= 1'b0;
      sof_due_r  <= 1'b0;
      sof_cmd_r  <= 1'b0;
      sof_cnt_r  <= FRAME_LAST;
    end else if (soft_rst_r) begin
      busy_r     <= 1'b0;
      stop_req_r <= 1'b0;
      sof_due_r  <= 1'b0;
      sof_cmd_r  <= 1'b0;
      sof_cnt_r  <= FRAME_LAST;
    end else begin
      if (wr && paddr == uhts_pkg::OFS_STATE &&
          !pwdata[uhts_pkg::ST_BUSY] && busy_r) begin
        stop_req_r <= 1'b1;
      end else if (stop_req_r && state_r != S_SOF) begin
        stop_req_r <= 1'b0;
      end
      if (sof_cmd_go) begin
        busy_r    <= 1'b1;
        sof_due_r <= 1'b1;
        sof_cmd_r <= 1'b1;
        sof_cnt_r <= FRAME_LAST;
      end else if (stop_req_r && state_r != S_SOF) begin
        busy_r    <= 1'b0;
        sof_due_r <= 1'b0;
        sof_cnt_r <= FRAME_LAST;
      end else if (busy_r && tick_r) begin
        if (sof_cnt_r == 14'h0000) begin
          sof_cnt_r <= FRAME_LAST;
          sof_due_r <= 1'b1;
        end else begin
          sof_cnt_r <= sof_cnt_r - 14'h0001;
        end
      end
      if (sof_go) begin
        sof_due_r <= 1'b0;
      end
      if (state_r == S_SOF && tok_end) begin
        sof_cmd_r <= 1'b0;
      end
    end
  end

  // Retry countdown, ticking in S_TOKEN and S_RETRY outside the freeze window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt_r <= 18'h00000;
    end else if (tok_go && retry_en_r) begin
      rcnt_r <= retry_r;
    end else if (tick_r && !freeze && rcnt_r != 18'h00000 &&
                 (state_r == S_TOKEN || state_r == S_RETRY)) begin
      rcnt_r <= rcnt_r - 18'h00001;
    end
  end

  // Sequencer and token output to the packet engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= S_IDLE;
      ret_r     <= S_IDLE;
      tok_start <= 1'b0;
      tok       <= '0;
    end else begin
      tok_start <= 1'b0;
      if (sof_go) begin
        tok_start  <= 1'b1;
        tok.pid    <= uhts_pkg::PID_SOF;
        tok.addr   <= addr_r;
        tok.endp   <= 4'h0;
        tok.toggle <= 1'b0;
        tok.frame  <= frame_r;
        ret_r      <= state_r;
        state_r    <= S_SOF;
      end else begin
        case (state_r)
          S_IDLE: begin
            if (tok_go) begin
              tok_start  <= 1'b1;
              tok.pid    <= type_r;
              tok.addr   <= addr_r;
              tok.endp   <= ep_r;
              tok.toggle <= tgl_r;
              tok.frame  <= frame_r;
              state_r    <= S_TOKEN;
            end
          end
          S_TOKEN: begin
            if (soft_rst_r) begin
              state_r <= S_IDLE;
            end else if (tok_end) begin
              state_r <= (tok_retry && retry_en_r) ? S_RETRY : S_IDLE;
            end
          end
          S_RETRY: begin
            if (!link_ok || rcnt_r == 18'h00000) begin
              state_r <= S_IDLE;
            end
          end
          S_SOF: begin
            if (tok_end) begin
              state_r <= soft_rst_r ? S_IDLE : ret_r;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // Toggle check and gated interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_err <= 1'b0;
      irq        <= 1'b0;
    end else begin
      toggle_err <= rx_tgl_valid & (rx_tgl != tgl_r);
      irq <= (ev_frame_r & fire_r) | (ev_done_r & cire_r);
    end
  end

  // Checks on the scheduling behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_attach_read: assert property (setup && paddr == uhts_pkg::OFS_STATE
    |=> prdata[uhts_pkg::ST_ATTACH] == $past(att_r))
    else $error("attach flag misread");
  a_frame_match: assert property (sof_go && !step_r && !soft_rst_r &&
    match_r == frame_r[7:0] |=> ev_frame_r)
    else $error("frame event not set");
  a_irq_gate: assert property (!fire_r && !cire_r |=> !irq)
    else $error("interrupt while disabled");
  a_retry_load: assert property (tok_go && retry_en_r
    |=> rcnt_r == $past(retry_r))
    else $error("retry count not loaded");
  a_retry_freeze: assert property (freeze && state_r == S_RETRY
    |=> rcnt_r == $past(rcnt_r))
    else $error("retry count moved in guard window");
  a_retry_keep: assert property (soft_rst_r |=> $stable(retry_r))
    else $error("retry time changed in soft reset");
  a_func_hide: assert property (setup && paddr == uhts_pkg::OFS_RETRY &&
    !host_mode |=> prdata[15:0] == 16'h0000)
    else $error("low retry bits visible");
  a_token_addr: assert property (tok_go |=> tok_start &&
    tok.addr == $past(addr_r) && tok.endp == $past(ep_r))
    else $error("token fields wrong");
  a_eof_defer: assert property (state_r == S_IDLE && is_data && eof_win
    |=> !tok_start || tok.pid == uhts_pkg::PID_SOF)
    else $error("data token in guard window");
  a_frame_step: assert property (state_r == S_SOF && tok_end && !soft_rst_r
    |=> frame_r == $past(frame_r) + 11'h001)
    else $error("frame number not advanced");
  a_done_clear: assert property (done_go && !soft_rst_r
    |=> type_r == uhts_pkg::PID_NONE && ev_done_r ##1
    irq == ($past(ev_frame_r & fire_r) | $past(cire_r)))
    else $error("completion not reported");
  a_sof_fields: assert property (tok_start && tok.pid == uhts_pkg::PID_SOF
    |-> tok.endp == 4'h0 && !tok.toggle)
    else $error("SOF carries endpoint or toggle");
  a_no_attach: assert property (!att_r |=> !tok_start)
    else $error("token sent while detached");

  c_token_sent: cover property (tok_go ##[1:50] tok_end);
  c_sof_sent: cover property (sof_go && sof_cmd_r);
  c_retry_path: cover property (state_r == S_RETRY ##1 state_r == S_IDLE);
  c_deferred: cover property (state_r == S_IDLE && is_data && eof_win);

endmodule

`default_nettype wire

/* logic/uhts_pkg.sv */
// Constants, field layout and carrier type of the host token scheduler.
// Assumes a 40 MHz APB clock and a 12 MHz full-speed bit rate.
`default_nettype none

package uhts_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] OFS_CORE  = 8'h00;
  localparam logic [7:0] OFS_HCTL  = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_MATCH = 8'h10;
  localparam logic [7:0] OFS_RETRY = 8'h14;
  localparam logic [7:0] OFS_ADDR  = 8'h18;
  localparam logic [7:0] OFS_GUARD = 8'h1c;
  localparam logic [7:0] OFS_FRAME = 8'h20;
  localparam logic [7:0] OFS_TOKEN = 8'h24;

  // Field positions
  localparam int CORE_RST   = 0;
  localparam int HCTL_STEP  = 0;
  localparam int HCTL_FIRE  = 1;
  localparam int HCTL_CIRE  = 2;
  localparam int HCTL_RETRY = 3;
  localparam int EV_FRAME   = 0;
  localparam int EV_DONE    = 1;
  localparam int ST_ATTACH  = 0;
  localparam int ST_SPEED   = 1;
  localparam int ST_BUSY    = 3;
  localparam int TK_TGL     = 7;
  localparam int TK_TYPE_LO = 4;
  localparam int TK_EP_LO   = 0;

  // Values after reset
  localparam logic        CORE_RST_INIT = 1'b0;
  localparam logic [7:0]  MATCH_INIT    = 8'h00;
  localparam logic [17:0] RETRY_INIT    = 18'h00000;
  localparam logic [6:0]  ADDR_INIT     = 7'h00;
  localparam logic [13:0] GUARD_INIT    = 14'h0000;
  localparam logic [10:0] FRAME_INIT    = 11'h000;

  // Token type codes
  localparam logic [2:0] PID_NONE  = 3'h0;
  localparam logic [2:0] PID_SETUP = 3'h1;
  localparam logic [2:0] PID_IN    = 3'h2;
  localparam logic [2:0] PID_OUT   = 3'h3;
  localparam logic [2:0] PID_SOF   = 3'h4;
  localparam logic [2:0] PID_ISOIN = 3'h5;
  localparam logic [2:0] PID_ISOUT = 3'h6;

  // Timing: bit tick by fractional accumulation in 0.5 MHz quanta
  localparam int CLK_HZ       = 40_000_000;
  localparam int BIT_HZ       = 12_000_000;
  localparam int FRAME_US     = 1000;
  localparam int QUANT_HZ     = 500_000;
  localparam int TICK_MOD     = CLK_HZ / QUANT_HZ;
  localparam int TICK_STEP    = BIT_HZ / QUANT_HZ;
  localparam int FRAME_BITS_D = BIT_HZ / 1_000_000 * FRAME_US;

  // Token handed to the packet engine
  typedef struct packed {
    logic [2:0]  pid;
    logic [6:0]  addr;
    logic [3:0]  endp;
    logic        toggle;
    logic [10:0] frame;
  } uhts_token_type;

endpackage

`default_nettype wire

/* tb/uhts_engine_model.sv */
// Packet engine stand-in: answers every token after a set delay.
// Assumes the scheduler on the same pclk; bench sets delay and faults.
`timescale 1ns/1ps
`default_nettype none
module uhts_engine_model (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Token side
  input  wire logic                     tok_start,
  input  wire uhts_pkg::uhts_token_type tok,
  output logic                          tok_end,
  output logic                          tok_retry,
  output logic                          rx_tgl_valid,
  output logic                          rx_tgl,
  // Bench knobs
  input  wire logic [7:0]               lat,
  input  wire logic                     want_retry,
  input  wire logic                     tgl_flip
);
  logic [7:0] cnt_r;
  logic       busy_r;
  // One answer per token; idle toggle line wiggles so stale data shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      tok_end <= 1'b0;
      tok_retry <= 1'b0;
      rx_tgl_valid <= 1'b0;
      rx_tgl <= 1'b0;
    end else begin
      tok_end <= 1'b0;
      tok_retry <= 1'b0;
      rx_tgl_valid <= 1'b0;
      rx_tgl <= ~rx_tgl;
      if (tok_start) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
        // Received toggle only for data tokens, flipped on demand
        if (cnt_r == 8'h01 && tok.pid != uhts_pkg::PID_SOF) begin
          rx_tgl_valid <= 1'b1;
          rx_tgl <= tok.toggle ^ tgl_flip;
        end
        if (cnt_r == 8'h00) begin
          busy_r <= 1'b0;
          tok_end <= 1'b1;
          tok_retry <= want_retry;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the host token scheduler.
// Assumes the engine stand-in on the token side and APB from here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int FB = 200;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lat;
  logic [31:0] pwdata, prdata, d;
  logic        attach, fs, host_mode, tok_start, tok_end, tok_retry;
  logic        rx_tgl_valid, rx_tgl, toggle_err, irq, want_retry;
  logic        tgl_flip, e, tg;
  logic [6:0]  ad;
  logic [3:0]  ep;
  logic [10:0] fr;
  uhts_pkg::uhts_token_type tok, seen;
  int          err_total, comparisons, n_tok, n_terr, i, n0, g;
  realtime     t_last, t_prev;

  uhts_token_sched #(.FRAME_BITS(FB)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dev_attach_pin(attach),
    .dev_full_speed_pin(fs), .host_mode(host_mode),
    .tok_start(tok_start), .tok(tok), .tok_end(tok_end),
    .tok_retry(tok_retry), .rx_tgl_valid(rx_tgl_valid),
    .rx_tgl(rx_tgl), .toggle_err(toggle_err), .irq(irq));
  uhts_engine_model ENG (
    .pclk(pclk), .presetn(presetn), .tok_start(tok_start), .tok(tok),
    .tok_end(tok_end), .tok_retry(tok_retry),
    .rx_tgl_valid(rx_tgl_valid), .rx_tgl(rx_tgl), .lat(lat),
    .want_retry(want_retry), .tgl_flip(tgl_flip));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Token and toggle-error snoop, mid-cycle so values are settled
  always @(negedge pclk) begin
    if (tok_start === 1'b1) begin
      seen = tok;
      n_tok++;
      t_prev = t_last;
      t_last = $realtime;
    end
    if (toggle_err === 1'b1) n_terr++;
  end

  task automatic wrap_up();
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
             err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_tok(input uhts_pkg::uhts_token_type got,
                         input uhts_pkg::uhts_token_type exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; idle cycle after so strobes never clash
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, wd, rd, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic er;
    apb(1'b0, a, 32'h0, v, er);
  endtask

  // Bounded wait for the token count to reach a target
  task automatic wait_n(input int tgt, input int lim);
    repeat (lim) if (n_tok < tgt) @(posedge pclk);
    if (n_tok < tgt) begin
      err_total++;
      wrap_up();
    end
  endtask

  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {attach, want_retry, tgl_flip} = '0;
    fs = 1'b1;
    host_mode = 1'b1;
    lat = 8'h06;
    void'($urandom(5));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(uhts_pkg::OFS_MATCH, d);
    chk_val(d, 32'h0);
    rd(uhts_pkg::OFS_TOKEN, d);
    chk_val(d, 32'h0);
    rd(uhts_pkg::OFS_STATE, d);
    chk_val(d & 32'h1, 32'h0);
    apb(1'b0, 8'h3c, 32'h0, d, e);
    chk_val({31'h0, e}, 32'h1);
    n0 = n_tok;
    wr(uhts_pkg::OFS_TOKEN, 32'h20);
    repeat (60) @(posedge pclk);
    chk_val(n_tok, n0);
    wr(uhts_pkg::OFS_TOKEN, 32'h0);
    end_test("detached");
    attach <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(uhts_pkg::OFS_STATE, d);
    chk_val(d & 32'h3, 32'h3);
    wr(uhts_pkg::OFS_HCTL, 32'h4);
    // Every data token kind, random target, OUT gets a bad toggle
    for (i = 1; i < 7; i++) begin
      if (i == 4) continue;
      ad = 7'($urandom);
      ep = 4'($urandom);
      tg = 1'($urandom);
      tgl_flip <= (i == 3);
      wr(uhts_pkg::OFS_ADDR, {25'h0, ad});
      n0 = n_tok;
      wr(uhts_pkg::OFS_TOKEN, {24'h0, tg, 3'(i), ep});
      wait_n(n0 + 1, 40);
      chk_tok(seen, {3'(i), ad, ep, tg, seen.frame});
      repeat (30) @(posedge pclk);
      rd(uhts_pkg::OFS_TOKEN, d);
      chk_val(d, {24'h0, tg, 3'h0, ep});
      rd(uhts_pkg::OFS_EVENT, d);
      chk_val(d & 32'h2, 32'h2);
      chk_val({31'h0, irq}, 32'h1);
      wr(uhts_pkg::OFS_EVENT, 32'h0);
      @(negedge pclk);
      chk_val({31'h0, irq}, 32'h0);
    end
    tgl_flip <= 1'b0;
    chk_val(n_terr, 1);
    n0 = n_tok;
    wr(uhts_pkg::OFS_TOKEN, 32'h70);
    repeat (60) @(posedge pclk);
    chk_val(n_tok, n0);
    wr(uhts_pkg::OFS_TOKEN, 32'h0);
    end_test("tokens");
    // Retry after 60 bit ticks, about 200 clocks
    wr(uhts_pkg::OFS_RETRY, 32'd60);
    wr(uhts_pkg::OFS_HCTL, 32'hc);
    want_retry <= 1'b1;
    n0 = n_tok;
    wr(uhts_pkg::OFS_TOKEN, 32'h20);
    wait_n(n0 + 1, 40);
    repeat (12) @(posedge pclk);
    want_retry <= 1'b0;
    wait_n(n0 + 2, 400);
    g = int'((t_last - t_prev) / 25.0);
    chk_val(32'(g >= 190 && g <= 215), 32'h1);
    chk_val(32'(seen.pid), 32'(uhts_pkg::PID_IN));
    repeat (30) @(posedge pclk);
    wr(uhts_pkg::OFS_RETRY, 32'h2003c);
    wr(uhts_pkg::OFS_CORE, 32'h1);
    wr(uhts_pkg::OFS_RETRY, 32'h5);
    rd(uhts_pkg::OFS_RETRY, d);
    chk_val(d, 32'h2003c);
    wr(uhts_pkg::OFS_CORE, 32'h0);
    host_mode <= 1'b0;
    rd(uhts_pkg::OFS_RETRY, d);
    chk_val(d, 32'h20000);
    wr(uhts_pkg::OFS_RETRY, 32'h1);
    host_mode <= 1'b1;
    rd(uhts_pkg::OFS_RETRY, d);
    chk_val(d, 32'h0003c);
    end_test("retry");
    // Frames: match on first SOF only, guard of 150 bit times
    fr = 11'($urandom);
    wr(uhts_pkg::OFS_FRAME, {21'h0, fr});
    wr(uhts_pkg::OFS_MATCH, {24'h0, fr[7:0]});
    wr(uhts_pkg::OFS_GUARD, 32'd150);
    wr(uhts_pkg::OFS_HCTL, 32'h2);
    n0 = n_tok;
    wr(uhts_pkg::OFS_TOKEN, 32'h4f);
    wait_n(n0 + 1, 40);
    chk_tok(seen, {uhts_pkg::PID_SOF, ad, 4'h0, 1'b0,
                   fr});
    repeat (20) @(posedge pclk);
    rd(uhts_pkg::OFS_STATE, d);
    chk_val(d & 32'h8, 32'h8);
    rd(uhts_pkg::OFS_FRAME, d);
    chk_val(d, {21'h0, fr + 11'h1});
    rd(uhts_pkg::OFS_EVENT, d);
    chk_val(d & 32'h1, 32'h1);
    chk_val({31'h0, irq}, 32'h1);
    wr(uhts_pkg::OFS_EVENT, 32'h0);
    wait_n(n0 + 2, 800);
    g = int'((t_last - t_prev) / 25.0);
    chk_val(32'(g >= 655 && g <= 680), 32'h1);
    chk_val(32'(seen.frame), {21'h0, fr + 11'h1});
    repeat (20) @(posedge pclk);
    rd(uhts_pkg::OFS_EVENT, d);
    chk_val(d & 32'h1, 32'h0);
    chk_val({31'h0, irq}, 32'h0);
    repeat (280) @(posedge pclk);
    wr(uhts_pkg::OFS_TOKEN, 32'h20);
    wait_n(n0 + 3, 800);
    chk_val(32'(seen.pid), 32'(uhts_pkg::PID_SOF));
    wait_n(n0 + 4, 100);
    chk_val(32'(seen.pid), 32'(uhts_pkg::PID_IN));
    repeat (30) @(posedge pclk);
    wr(uhts_pkg::OFS_STATE, 32'h0);
    for (i = 0; i < 40; i++) begin
      rd(uhts_pkg::OFS_STATE, d);
      if (d[3] === 1'b0) break;
    end
    chk_val(d & 32'h8, 32'h0);
    wr(uhts_pkg::OFS_CORE, 32'h1);
    rd(uhts_pkg::OFS_FRAME, d);
    chk_val(d, 32'h0);
    wr(uhts_pkg::OFS_CORE, 32'h0);
    end_test("frames");
    wrap_up();
  end
endmodule
`default_nettype wire
